/* File: rtl/gsm_pkg.sv */
// Constants, types and register map for the guard output state machine
//
// Overview of operation
// - Run state: both safety outputs on, green run indicator lit.
// - Start press-and-release in run state causes no state change.
// - Stop state: both safety outputs off, red stop indicator lit.
// - Run, stop and hold states drive auxiliary output per configured behaviour.
// - Hold state: safety outputs off, red and yellow indicators steadily lit.
// - Hold to run only with clear zone and completed start press-release.
// - Fault lockout: outputs off, red lit, yellow flashes, auxiliary forced off.
// - Fault lockout held until fault corrected and cleared by software or reset; start cannot release it.
// - Internal fault enters lockout from any state in any mode.
// - Automatic mode: outputs off after reset, then run when zone clear.
// - Automatic mode: obstruction gives stop, clearing returns to run unaided.
// - Start-hold modes: after reset go to hold once zone clear and no fault.
// - Start-hold mode: after first run, stop and clear return straight to run.
// - Start/restart-hold mode: clearing after stop goes to hold, not run.
// - Start press-release ignored while the detection zone is not clear.
// - Operating mode comes from stored configuration written by software.
package gsm_pkg;

	// Operating modes
	localparam logic [1:0] MODE_AUTO = 2'h0;
	localparam logic [1:0] MODE_START_HOLD = 2'h1;
	localparam logic [1:0] MODE_RESTART_HOLD = 2'h2;

	// Auxiliary behaviour codes
	localparam logic [1:0] AUX_FOLLOW = 2'h0;
	localparam logic [1:0] AUX_INVERT = 2'h1;
	localparam logic [1:0] AUX_OFF = 2'h2;
	localparam logic [1:0] AUX_ON = 2'h3;

	// Register byte offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFF_IRQ_MASK = 4'hC;

	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_AUX_LSB = 2;
	localparam int CTRL_FAULT_CLR_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// Interrupt event bits
	localparam int IRQ_RUN = 0;
	localparam int IRQ_STOP = 1;
	localparam int IRQ_HOLD = 2;
	localparam int IRQ_FAULT = 3;
	localparam int IRQ_W = 4;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Fault indicator flash half period
	localparam int CLK_HZ = 200_000_000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

	typedef enum logic [3:0] {
		ST_STOP = 4'h1,
		ST_RUN = 4'h2,
		ST_HOLD = 4'h4,
		ST_FAULT = 4'h8
	} gsm_state_t;

endpackage : gsm_pkg

/* File: rtl/gsm_guard_fsm.sv */
// Guard output state machine with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module gsm_guard_fsm #(
	parameter int FLASH_HALF = gsm_pkg::FLASH_HALF_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Sensing and operator
	input wire logic zone_clear,
	input wire logic blank_ok,
	input wire logic start_btn,
	input wire logic fault_det,
	// Safety and indicator outputs
	output logic safety_output_a,
	output logic safety_output_b,
	output logic aux_out,
	output logic led_green,
	output logic led_red,
	output logic led_yellow,
	output logic irq,
	// AXI4-Lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import gsm_pkg::*;

	gsm_state_t state_ff, nxt_state;
	logic [4:0] ctrl_ff;
	logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, evt;
	logic start_q_ff, armed_ff, start_evt;
	logic fault_latch_ff;
	logic [31:0] flash_cnt_ff;
	logic flash_ff;
	logic ran_ff;
	logic zone_ok;
	logic [1:0] mode, aux_cfg;

	// Write channel holding
	logic aw_full_ff, w_full_ff;
	logic [3:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic do_write;
	logic fault_clr;

	assign mode = ctrl_ff[CTRL_MODE_LSB +: 2];
	assign aux_cfg = ctrl_ff[CTRL_AUX_LSB +: 2];
	assign zone_ok = zone_clear | blank_ok;

	// Start recognised on release after a registered press
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			start_q_ff <= 1'b0;
			armed_ff <= 1'b0;
		end else begin
			start_q_ff <= start_btn;
			if (start_q_ff && !zone_ok)
				armed_ff <= 1'b0;
			else if (start_q_ff)
				armed_ff <= 1'b1;
			else if (start_evt)
				armed_ff <= 1'b0;
		end
	end
	assign start_evt = armed_ff & ~start_q_ff & zone_ok;

	// Fault latch survives until software confirms correction
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			fault_latch_ff <= 1'b0;
		else if (fault_det)
			fault_latch_ff <= 1'b1;
		else if (fault_clr)
			fault_latch_ff <= 1'b0;
	end

	// State transitions
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_STOP: begin
				if (zone_ok) begin
					if (mode == MODE_AUTO)
						nxt_state = ST_RUN;
					else if (mode == MODE_START_HOLD && ran_ff)
						nxt_state = ST_RUN;
					else
						nxt_state = ST_HOLD;
				end
			end
			ST_RUN: begin
				if (!zone_ok)
					nxt_state = ST_STOP;
				// Start edges do nothing here
			end
			ST_HOLD: begin
				if (!zone_ok)
					nxt_state = ST_STOP;
				else if (start_evt)
					nxt_state = ST_RUN;
			end
			ST_FAULT: begin
				if (!fault_latch_ff && !fault_det)
					nxt_state = ST_STOP;
			end
		endcase
		if (fault_det || fault_latch_ff)
			nxt_state = ST_FAULT;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			state_ff <= ST_STOP;
		else
			state_ff <= nxt_state;
	end

	// Remember first run entry; cleared by fault so restart needs a start
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ran_ff <= 1'b0;
		else if (state_ff == ST_FAULT)
			ran_ff <= 1'b0;
		else if (state_ff == ST_RUN)
			ran_ff <= 1'b1;
	end

	// Yellow flash timer for the lockout indicator
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flash_cnt_ff <= 32'h0;
			flash_ff <= 1'b0;
		end else if (state_ff != ST_FAULT) begin
			flash_cnt_ff <= 32'h0;
			flash_ff <= 1'b1;
		end else if (flash_cnt_ff >= 32'(FLASH_HALF - 1)) begin
			flash_cnt_ff <= 32'h0;
			flash_ff <= ~flash_ff;
		end else begin
			flash_cnt_ff <= flash_cnt_ff + 32'h1;
		end
	end

	// Outputs registered from state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
			aux_out <= 1'b0;
			led_green <= 1'b0;
			led_red <= 1'b1;
			led_yellow <= 1'b0;
		end else begin
			safety_output_a <= (state_ff == ST_RUN);
			safety_output_b <= (state_ff == ST_RUN);
			led_green <= (state_ff == ST_RUN);
			led_red <= (state_ff != ST_RUN);
			if (state_ff == ST_HOLD)
				led_yellow <= 1'b1;
			else if (state_ff == ST_FAULT)
				led_yellow <= flash_ff;
			else
				led_yellow <= 1'b0;
			if (state_ff == ST_FAULT)
				aux_out <= 1'b0;
			else begin
				unique case (aux_cfg)
					AUX_FOLLOW: aux_out <= (state_ff == ST_RUN);
					AUX_INVERT: aux_out <= (state_ff != ST_RUN);
					AUX_OFF: aux_out <= 1'b0;
					AUX_ON: aux_out <= 1'b1;
				endcase
			end
		end
	end

	// State entry events
	always_comb begin
		evt = '0;
		if (nxt_state != state_ff) begin
			evt[IRQ_RUN] = (nxt_state == ST_RUN);
			evt[IRQ_STOP] = (nxt_state == ST_STOP);
			evt[IRQ_HOLD] = (nxt_state == ST_HOLD);
			evt[IRQ_FAULT] = (nxt_state == ST_FAULT);
		end
	end

	// AXI4-Lite write path: address and data accepted in either order
	assign s_axi_awready = ~aw_full_ff & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full_ff & ~s_axi_bvalid;
	assign do_write = aw_full_ff & w_full_ff & ~s_axi_bvalid;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_ff <= 1'b0;
			aw_addr_ff <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			w_full_ff <= 1'b0;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_ff <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (do_write) begin
			w_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_ff[3:2] == OFF_STATUS[3:2]) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control register; fault-clear bit is a one-shot
	assign fault_clr = do_write && aw_addr_ff[3:2] == OFF_CTRL[3:2] && w_strb_ff[0]
		&& w_data_ff[CTRL_FAULT_CLR_BIT];
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ctrl_ff <= CTRL_RESET;
		else if (do_write && aw_addr_ff[3:2] == OFF_CTRL[3:2] && w_strb_ff[0])
			ctrl_ff <= {1'b0, w_data_ff[3:0]};
	end

	// Interrupt mask and sticky status; a new event wins over the clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irq_mask_ff <= IRQ_MASK_RESET;
		else if (do_write && aw_addr_ff[3:2] == OFF_IRQ_MASK[3:2] && w_strb_ff[0])
			irq_mask_ff <= w_data_ff[IRQ_W-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irq_stat_ff <= '0;
		else if (do_write && aw_addr_ff[3:2] == OFF_IRQ_STAT[3:2] && w_strb_ff[0])
			irq_stat_ff <= (irq_stat_ff & ~w_data_ff[IRQ_W-1:0]) | evt;
		else
			irq_stat_ff <= irq_stat_ff | evt;
	end
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// AXI4-Lite read path, one cycle after address
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr[3:2])
				OFF_CTRL[3:2]: s_axi_rdata <= {28'h0, ctrl_ff[3:0]};
				OFF_STATUS[3:2]: s_axi_rdata <= {25'h0, fault_latch_ff, ran_ff,
					zone_ok, state_ff};
				OFF_IRQ_STAT[3:2]: s_axi_rdata <= {28'h0, irq_stat_ff};
				OFF_IRQ_MASK[3:2]: s_axi_rdata <= {28'h0, irq_mask_ff};
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : gsm_guard_fsm
`default_nettype wire

/* File: test/gsm_guard_fsm_checker.sv */
// Port-level assertions for the guard output state machine
`timescale 1ns/100ps
`default_nettype none
module gsm_guard_fsm_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Sensing
	input wire logic zone_clear,
	input wire logic blank_ok,
	input wire logic fault_det,
	// Outputs
	input wire logic safety_output_a,
	input wire logic safety_output_b,
	input wire logic aux_out,
	input wire logic led_green,
	input wire logic led_red,
	input wire logic led_yellow,
	// Bus
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_RUN_OUT: assert property (safety_output_a |-> safety_output_b && led_green && !led_red)
		else $error("run outputs inconsistent");
	AST_STOP_OUT: assert property (!safety_output_a |-> !safety_output_b && led_red && !led_green)
		else $error("stop outputs inconsistent");
	AST_YEL_OFF: assert property (led_yellow |-> led_red && !safety_output_a)
		else $error("yellow lit with outputs on");
	AST_FLT_OFF: assert property (fault_det |-> ##[1:4] !safety_output_a)
		else $error("fault did not drop outputs");
	AST_FLT_AUX: assert property (fault_det [*5] |-> !aux_out)
		else $error("aux on during fault");
	AST_BLOCKED: assert property ((!zone_clear && !blank_ok) [*5] |-> !safety_output_a)
		else $error("outputs on with zone blocked");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while answering");
	cover property ($rose(safety_output_a));
	cover property ($rose(led_yellow) && led_red);
	cover property ($fell(safety_output_a) && fault_det);
endmodule : gsm_guard_fsm_checker
bind gsm_guard_fsm gsm_guard_fsm_checker u_chk (.clk_sys, .rst_n, .zone_clear, .blank_ok,
	.fault_det, .safety_output_a, .safety_output_b, .aux_out, .led_green, .led_red, .led_yellow,
	.s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready);
`default_nettype wire

/* File: test/gsm_op_model.sv */
// Operator start button model: one press held for a set number of cycles
`timescale 1ns/100ps
`default_nettype none
module gsm_op_model (
	// Clock
	input wire logic clk_sys,
	// Request from the bench
	input wire logic go,
	input wire logic [7:0] len,
	// Button
	output logic start_btn,
	output logic busy
);
	logic [7:0] cnt_ff = 8'h00;
	// Button has no bounce, so a held press is one clean level
	assign start_btn = cnt_ff != 8'h00;
	assign busy = start_btn;
	always_ff @(posedge clk_sys) begin
		if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
		else if (go) cnt_ff <= len;
	end
endmodule : gsm_op_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the guard output state machine
`timescale 1ns/100ps
`default_nettype none
module tb;
	import gsm_pkg::*;
	logic clk_sys = 0, rst_n = 0, zone_clear = 1, blank_ok = 0, fault_det = 0, go = 0, y;
	logic safety_output_a, safety_output_b, aux_out, led_green, led_red, led_yellow, irq;
	logic busy, start_btn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] len = 0;
	int num_errors = 0, tests_run = 0, seed = 32'h5B55, i, m, ac, t;
	wire [5:0] outs = {safety_output_a, safety_output_b, led_green, led_red, led_yellow, aux_out};
	always #2.5 clk_sys = ~clk_sys;
	// Short flash period keeps the fault scenario brief
	gsm_guard_fsm #(.FLASH_HALF(4)) DUT (.*);
	gsm_op_model OP (.*);
	function logic [5:0] eo(input logic [3:0] st, input int ac);
		logic r;
		r = st == ST_RUN;
		return {r, r, r, !r, st == ST_HOLD, ac == AUX_FOLLOW ? r : ac == AUX_INVERT ? !r : ac == AUX_ON};
	endfunction : eo
	function logic [3:0] after_clear(input int m);
		return (m == MODE_AUTO || m == MODE_START_HOLD) ? ST_RUN : ST_HOLD;
	endfunction : after_clear
	task report_and_stop;
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	task chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	task hang(input int n);
		if (n >= 40) begin
			num_errors++;
			report_and_stop;
		end
	endtask : hang
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw, tk;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tk = s_axi_bvalid && s_axi_bready;
			if (tk) chk("bresp", er, s_axi_bresp);
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tk) s_axi_bready <= 1'h0;
			if (tk) break;
		end
		hang(n);
	endtask : wr
	task rdr(input logic [3:0] a);
		int n;
		logic ta, tk;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge clk_sys);
			ta = s_axi_arvalid && s_axi_arready;
			tk = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			if (tk) chk("rresp", RESP_OKAY, s_axi_rresp);
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'h0;
			if (tk) s_axi_rready <= 1'h0;
			if (tk) break;
		end
		hang(n);
	endtask : rdr
	task wait_sa(input logic e);
		int n;
		for (n = 0; n < 40 && safety_output_a !== e; n++) @(negedge clk_sys);
		hang(n);
		cyc(2);
	endtask : wait_sa
	task press(input logic [7:0] l);
		int n;
		@(posedge clk_sys) begin
			go <= 1'h1;
			len <= l;
		end
		@(posedge clk_sys) go <= 1'h0;
		// Button model loads its count at this edge; look once it has settled
		@(negedge clk_sys);
		for (n = 0; n < 40 && busy !== 1'h0; n++) @(negedge clk_sys);
		hang(n);
	endtask : press
	initial begin
		cyc(7);
		chk("reset", eo(ST_STOP, AUX_OFF), outs);
		@(posedge clk_sys) rst_n <= 1'h1;
		wait_sa(1'h1);
		chk("outs", eo(ST_RUN, AUX_FOLLOW), outs);
		rdr(OFF_STATUS);
		chk("status", 32'h32, rd);
		wr(OFF_STATUS, 32'hF, RESP_SLVERR);
		press(8'h3);
		cyc(6);
		chk("outs", eo(ST_RUN, AUX_FOLLOW), outs);
		// Mode code 3 is included: it must act as start/restart hold
		for (i = 0; i < 6; i++) begin
			m = i % 4;
			ac = $unsigned($random(seed)) % 4;
			wr(OFF_CTRL, m | ac << 2, RESP_OKAY);
			rdr(OFF_CTRL);
			chk("ctrl", m | ac << 2, rd);
			@(posedge clk_sys) zone_clear <= 1'h0;
			press(8'h2);
			cyc($unsigned($random(seed)) % 20 + 6);
			chk("outs", eo(ST_STOP, ac), outs);
			@(posedge clk_sys) zone_clear <= 1'h1;
			cyc(6);
			chk("outs", eo(after_clear(m), ac), outs);
			if (after_clear(m) == ST_HOLD) begin
				@(posedge clk_sys) begin
					go <= 1'h1;
					len <= 8'h28;
				end
				@(posedge clk_sys) go <= 1'h0;
				cyc(30);
				chk("outs", eo(ST_HOLD, ac), outs);
				wait_sa(1'h1);
				chk("outs", eo(ST_RUN, ac), outs);
			end
		end
		@(posedge clk_sys) begin
			zone_clear <= 1'h0;
			blank_ok <= 1'h1;
		end
		cyc(8);
		chk("outs", eo(ST_RUN, ac), outs);
		wr(OFF_IRQ_MASK, 32'h8, RESP_OKAY);
		@(posedge clk_sys) fault_det <= 1'h1;
		cyc(6);
		chk("fault", 5'h02, {outs[5:2], outs[0]});
		chk("irq", 1'h1, irq);
		t = 0;
		repeat (20) begin
			y = led_yellow;
			cyc(1);
			t += y != led_yellow;
		end
		chk("flash", 1'h1, t > 3);
		@(posedge clk_sys) fault_det <= 1'h0;
		press(8'h2);
		cyc(6);
		chk("fault", 5'h02, {outs[5:2], outs[0]});
		@(posedge clk_sys) begin
			rst_n <= 1'h0;
			fault_det <= 1'h1;
		end
		cyc(2);
		@(posedge clk_sys) rst_n <= 1'h1;
		cyc(6);
		chk("fault", 5'h02, {outs[5:2], outs[0]});
		@(posedge clk_sys) fault_det <= 1'h0;
		wr(OFF_CTRL, 32'h10, RESP_OKAY);
		wait_sa(1'h1);
		chk("irq", 1'h0, irq);
		wr(OFF_IRQ_MASK, 32'h8, RESP_OKAY);
		chk("irq", 1'h1, irq);
		wr(OFF_IRQ_STAT, 32'h8, RESP_OKAY);
		chk("irq", 1'h0, irq);
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
